//--- core/rtp_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the reload timer
// Assumes: APB byte address is four times the register index
// Notes:   Include by bare name; definitions only
//
// How it works
// R1: Three-bit prescale field divides the tick by 1 up to 128.
// R2: Counter rollover past FFFF sets the overflow flag, control bit 4.
// R3: Entering this timer's interrupt service routine clears the overflow flag.
// R4: Software may write the overflow flag to one or zero.
// R5: Run control bit 3 low halts counting; high lets it count.
// R6: Software writes reload bytes only while the timer is halted.
// R7: Bit 5 picks first serial port baud source: timer 1 or overflow.
// R8: Bit 7 doubles second serial port baud rate in its mode 2.
// R9: Bit 6 maps second port control bit 7 to mode or framing error.
// R10: Reload-low register holds reload value bits 7:0.
// R11: Reload-high register holds reload value bits 15:8.
// R12: Count up per tick; on overflow load reload value and continue.
`ifndef RTP_DEFS_SVH
`define RTP_DEFS_SVH

`define RTP_ADDR_W       12
`define RTP_IDX_CTRL     8'hC4
`define RTP_IDX_RLOW     8'hC5
`define RTP_IDX_RHIGH    8'hC6
`define RTP_IDX_COUNT    8'hC7
`define RTP_IDX_ISTAT    8'hC8
`define RTP_IDX_IMASK    8'hC9

`define RTP_CTRL_RST     8'h00
`define RTP_RLOW_RST     8'h00
`define RTP_RHIGH_RST    8'h00
`define RTP_COUNT_RST    16'h0000
`define RTP_COUNT_MAX    16'hFFFF

`define RTP_BIT_DOUBLE   7
`define RTP_BIT_ERRSEL   6
`define RTP_BIT_BAUDSEL  5
`define RTP_BIT_OVF      4
`define RTP_BIT_RUN      3
`define RTP_PS_HI        2
`define RTP_PS_LO        0

`define RTP_PRE_W        7

`endif

//--- core/rtp_pkg.sv
// Purpose: Types shared by the reload timer modules
// Assumes: Constants live in rtp_defs.svh
// Notes:   Nothing is imported; use rtp_pkg::name
package rtp_pkg;

  typedef enum logic [0:0] {
    RTP_IDLE = 1'b0,
    RTP_ACK  = 1'b1
  } rtp_apb_phase_t;

  typedef struct packed {
    rtp_apb_phase_t phase;
    logic [31:0]    prdata;
    logic           pslverr;
  } rtp_apb_state_t;

  typedef struct packed {
    logic [6:0] cnt;
  } rtp_pre_state_t;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  rlow;
    logic [7:0]  rhigh;
    logic [15:0] count;
    logic        istat;
    logic        imask;
    logic        irq;
    logic        uart0_baud;
    logic        sp_baud_dbl;
    logic        sp_bit7_rd;
    logic        sp_bit7_fe;
  } rtp_state_t;

endpackage

//--- core/rtp_prescaler.sv
// Purpose: Power-of-two tick divider for the reload timer
// Assumes: Counter restarts from zero whenever run is low
// Notes:   Tick is combinational; the parent registers its effects
`timescale 1ns/1ps
`default_nettype none
`include "rtp_defs.svh"
module rtp_prescaler (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [2:0] i_code,
  output logic            o_tick
);

  rtp_pkg::rtp_pre_state_t st_reg;
  rtp_pkg::rtp_pre_state_t st_next;
  logic [`RTP_PRE_W-1:0]   mask;

  // R1: ratio 2**code
  always_comb begin
    st_next = st_reg;
    mask    = 7'((8'h01 << i_code) - 8'h01);
    o_tick  = i_run && ((st_reg.cnt & mask) == mask);
    if (!i_run) begin
      st_next.cnt = 7'h00;
    end else begin
      st_next.cnt = 7'(st_reg.cnt + 7'h01);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule
`default_nettype wire

//--- core/rtp_apb_slave.sv
// Purpose: APB slave front end with one-cycle access phase
// Assumes: Parent decodes paddr and supplies read data and hit
// Notes:   pready rises in the first access cycle; no wait states
`timescale 1ns/1ps
`default_nettype none
module rtp_apb_slave (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic        i_hit,
  input  wire logic [31:0] i_rdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic             o_wr_en
);

  rtp_pkg::rtp_apb_state_t st_reg;
  rtp_pkg::rtp_apb_state_t st_next;

  always_comb begin
    st_next = st_reg;
    case (st_reg.phase)
      rtp_pkg::RTP_IDLE: begin
        if (i_psel && !i_penable) begin
          st_next.phase   = rtp_pkg::RTP_ACK;
          st_next.prdata  = i_pwrite ? 32'h0000_0000 : i_rdata;
          st_next.pslverr = !i_hit;
        end
      end
      rtp_pkg::RTP_ACK: begin
        st_next.phase   = rtp_pkg::RTP_IDLE;
        st_next.prdata  = 32'h0000_0000;
        st_next.pslverr = 1'b0;
      end
      default: begin
        st_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Unmapped writes are answered with an error and store nothing
  assign o_pready  = (st_reg.phase == rtp_pkg::RTP_ACK);
  assign o_prdata  = st_reg.prdata;
  assign o_pslverr = st_reg.pslverr;
  assign o_wr_en   = o_pready && i_psel && i_penable && i_pwrite && !st_reg.pslverr;

endmodule
`default_nettype wire

//--- core/rtp_timer.sv
// Purpose: 16-bit auto-reload timer with prescaler and serial-port control bits
// Assumes: Single clock; APB register access; reload writes only while halted
// Notes:   Hardware set of the overflow flag wins over any clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "rtp_defs.svh"
module rtp_timer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // APB
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // CPU interrupt entry for this timer
  input  wire logic        i_isr_enter,
  output logic             o_irq,
  // Serial port hooks
  input  wire logic        i_timer1_ovf,
  input  wire logic        i_sp_mode2,
  input  wire logic        i_sp_mode_bit,
  input  wire logic        i_sp_framing_error,
  output logic             o_uart0_baud_tick,
  output logic             o_sp_baud_double,
  output logic             o_sp_bit7_read,
  output logic             o_sp_bit7_to_fe
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  localparam logic [2:0] SEL_NONE  = 3'h0;
  localparam logic [2:0] SEL_CTRL  = 3'h1;
  localparam logic [2:0] SEL_RLOW  = 3'h2;
  localparam logic [2:0] SEL_RHIGH = 3'h3;
  localparam logic [2:0] SEL_COUNT = 3'h4;
  localparam logic [2:0] SEL_ISTAT = 3'h5;
  localparam logic [2:0] SEL_IMASK = 3'h6;

  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [2:0] decode(input logic [11:0] a);
    if (a == byte_addr(`RTP_IDX_CTRL)) begin
      decode = SEL_CTRL;
    end else if (a == byte_addr(`RTP_IDX_RLOW)) begin
      decode = SEL_RLOW;
    end else if (a == byte_addr(`RTP_IDX_RHIGH)) begin
      decode = SEL_RHIGH;
    end else if (a == byte_addr(`RTP_IDX_COUNT)) begin
      decode = SEL_COUNT;
    end else if (a == byte_addr(`RTP_IDX_ISTAT)) begin
      decode = SEL_ISTAT;
    end else if (a == byte_addr(`RTP_IDX_IMASK)) begin
      decode = SEL_IMASK;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  rtp_pkg::rtp_state_t st_reg;
  rtp_pkg::rtp_state_t st_next;
  logic [2:0]          sel;
  logic [31:0]         rdata;
  logic                wr_en;
  logic                tick;
  logic                ovf_event;
  logic                run;
  logic [2:0]          ps_code;
  logic                wr_ctrl;
  logic                wr_rlow;
  logic                wr_rhigh;
  logic                wr_istat;
  logic                wr_imask;

  assign sel      = decode(i_paddr);
  assign run      = st_reg.ctrl[`RTP_BIT_RUN];
  assign ps_code  = st_reg.ctrl[`RTP_PS_HI:`RTP_PS_LO];
  assign wr_ctrl  = wr_en && (sel == SEL_CTRL);
  assign wr_rlow  = wr_en && (sel == SEL_RLOW);
  assign wr_rhigh = wr_en && (sel == SEL_RHIGH);
  assign wr_istat = wr_en && (sel == SEL_ISTAT);
  assign wr_imask = wr_en && (sel == SEL_IMASK);

  always_comb begin
    case (sel)
      SEL_CTRL:  rdata = {24'h00_0000, st_reg.ctrl};
      SEL_RLOW:  rdata = {24'h00_0000, st_reg.rlow};
      SEL_RHIGH: rdata = {24'h00_0000, st_reg.rhigh};
      SEL_COUNT: rdata = {16'h0000, st_reg.count};
      SEL_ISTAT: rdata = {31'h0000_0000, st_reg.istat};
      SEL_IMASK: rdata = {31'h0000_0000, st_reg.imask};
      default:   rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  rtp_apb_slave u_apb (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_hit     (sel != SEL_NONE),
    .i_rdata   (rdata),
    .o_pready  (o_pready),
    .o_prdata  (o_prdata),
    .o_pslverr (o_pslverr),
    .o_wr_en   (wr_en)
  );

  // R5: prescaler idles while halted
  rtp_prescaler u_pre (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_run     (run),
    .i_code    (ps_code),
    .o_tick    (tick)
  );

  // R2: rollover detect
  assign ovf_event = tick && (st_reg.count == `RTP_COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;
    if (wr_ctrl) begin
      st_next.ctrl = i_pwdata[7:0];
    end
    // R3: service entry clears the flag
    if (i_isr_enter) begin
      st_next.ctrl[`RTP_BIT_OVF] = 1'b0;
    end
    // R4: software value taken like a hardware change
    if (wr_ctrl) begin
      st_next.ctrl[`RTP_BIT_OVF] = i_pwdata[`RTP_BIT_OVF];
    end
    // R2: set wins over both clears
    if (ovf_event) begin
      st_next.ctrl[`RTP_BIT_OVF] = 1'b1;
    end
    // R10: reload low byte
    if (wr_rlow) begin
      st_next.rlow = i_pwdata[7:0];
    end
    // R11: reload high byte
    if (wr_rhigh) begin
      st_next.rhigh = i_pwdata[7:0];
    end
    // R12: count up, reload on overflow
    if (ovf_event) begin
      st_next.count = {st_reg.rhigh, st_reg.rlow};
    end else if (tick) begin
      st_next.count = 16'(st_reg.count + 16'h0001);
    end
    if (wr_istat && i_pwdata[0]) begin
      st_next.istat = 1'b0;
    end
    if (ovf_event) begin
      st_next.istat = 1'b1;
    end
    if (wr_imask) begin
      st_next.imask = i_pwdata[0];
    end
    // Next values used so the output line follows status without lag
    st_next.irq = st_next.istat && st_next.imask;
    // R7: baud source select
    st_next.uart0_baud = st_reg.ctrl[`RTP_BIT_BAUDSEL] ? ovf_event : i_timer1_ovf;
    // R8: doubling only in mode 2
    st_next.sp_baud_dbl = st_reg.ctrl[`RTP_BIT_DOUBLE] && i_sp_mode2;
    // R9: bit 7 steering
    st_next.sp_bit7_rd = st_reg.ctrl[`RTP_BIT_ERRSEL] ? i_sp_framing_error : i_sp_mode_bit;
    st_next.sp_bit7_fe = st_reg.ctrl[`RTP_BIT_ERRSEL];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_reg       <= '0;
      st_reg.ctrl  <= `RTP_CTRL_RST;
      st_reg.rlow  <= `RTP_RLOW_RST;
      st_reg.rhigh <= `RTP_RHIGH_RST;
      st_reg.count <= `RTP_COUNT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_irq               = st_reg.irq;
  assign o_uart0_baud_tick   = st_reg.uart0_baud;
  assign o_sp_baud_double    = st_reg.sp_baud_dbl;
  assign o_sp_bit7_read      = st_reg.sp_bit7_rd;
  assign o_sp_bit7_to_fe     = st_reg.sp_bit7_fe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Cycles between ticks, valid only after a full interval at fixed settings
  logic [7:0] gap_cnt;
  logic       gap_ok;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !run || wr_ctrl) begin
      gap_cnt <= 8'h00;
      gap_ok  <= 1'b0;
    end else if (tick) begin
      gap_cnt <= 8'h00;
      gap_ok  <= 1'b1;
    end else begin
      gap_cnt <= 8'(gap_cnt + 8'h01);
    end
  end

  prescale_ratio_a: assert property ( // R1
    @(posedge i_sys_clk) disable iff (i_rst)
    (tick && gap_ok && run) |-> (9'(gap_cnt) + 9'h001 == (9'h001 << ps_code))
  ) else $error("tick spacing does not match prescale code");

  ovf_sets_flag_a: assert property ( // R2
    @(posedge i_sys_clk) disable iff (i_rst)
    ovf_event |=> (st_reg.ctrl[`RTP_BIT_OVF] && st_reg.istat)
  ) else $error("overflow did not set the flag");

  isr_clears_flag_a: assert property ( // R3
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_isr_enter && !ovf_event && !wr_ctrl) |=> !st_reg.ctrl[`RTP_BIT_OVF]
  ) else $error("service entry did not clear the flag");

  sw_flag_write_a: assert property ( // R4
    @(posedge i_sys_clk) disable iff (i_rst)
    (wr_ctrl && !ovf_event) |=> (st_reg.ctrl[`RTP_BIT_OVF] == $past(i_pwdata[4]))
  ) else $error("software flag write not taken");

  halt_holds_count_a: assert property ( // R5
    @(posedge i_sys_clk) disable iff (i_rst)
    (!run ##1 !run) |-> ($stable(st_reg.count) && !tick)
  ) else $error("count moved while halted");

  count_step_a: assert property ( // R12
    @(posedge i_sys_clk) disable iff (i_rst)
    (tick && !ovf_event) |=> (st_reg.count == 16'($past(st_reg.count) + 16'h0001))
  ) else $error("count did not step by one");

  reload_on_ovf_a: assert property ( // R12
    @(posedge i_sys_clk) disable iff (i_rst)
    ovf_event |=> (st_reg.count == {$past(st_reg.rhigh), $past(st_reg.rlow)})
  ) else $error("overflow did not reload the count");

  reload_low_a: assert property ( // R10
    @(posedge i_sys_clk) disable iff (i_rst)
    wr_rlow |=> (st_reg.rlow == $past(i_pwdata[7:0]))
  ) else $error("reload low byte not stored");

  reload_high_a: assert property ( // R11
    @(posedge i_sys_clk) disable iff (i_rst)
    wr_rhigh |=> (st_reg.rhigh == $past(i_pwdata[7:0]))
  ) else $error("reload high byte not stored");

  baud_source_a: assert property ( // R7
    @(posedge i_sys_clk) disable iff (i_rst)
    ##1 (o_uart0_baud_tick ==
      ($past(st_reg.ctrl[5]) ? $past(ovf_event) : $past(i_timer1_ovf)))
  ) else $error("first port baud source wrong");

  baud_double_a: assert property ( // R8
    @(posedge i_sys_clk) disable iff (i_rst)
    (st_reg.ctrl[`RTP_BIT_DOUBLE] && i_sp_mode2) |=> o_sp_baud_double
  ) else $error("second port baud not doubled");

  bit7_mapping_a: assert property ( // R9
    @(posedge i_sys_clk) disable iff (i_rst)
    st_reg.ctrl[`RTP_BIT_ERRSEL] |=> (o_sp_bit7_to_fe &&
      (o_sp_bit7_read == $past(i_sp_framing_error)))
  ) else $error("bit 7 not mapped to framing error");

  irq_level_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    ##1 (o_irq == (st_reg.istat && st_reg.imask))
  ) else $error("interrupt line disagrees with status and mask");

  apb_one_wait_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_psel && !i_penable && !o_pready) |=> o_pready
  ) else $error("access phase not acknowledged at once");

  flag_sticky_a: assert property ( // R3
    @(posedge i_sys_clk) disable iff (i_rst)
    (st_reg.ctrl[`RTP_BIT_OVF] && !i_isr_enter && !wr_ctrl) |=> st_reg.ctrl[`RTP_BIT_OVF]
  ) else $error("overflow flag dropped without a clear");

  flag_set_only_a: assert property ( // R2
    @(posedge i_sys_clk) disable iff (i_rst)
    (!st_reg.ctrl[`RTP_BIT_OVF] && !ovf_event && !wr_ctrl) |=> !st_reg.ctrl[`RTP_BIT_OVF]
  ) else $error("overflow flag set without an overflow");

  istat_w1c_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (wr_istat && i_pwdata[0] && !ovf_event) |=> !st_reg.istat
  ) else $error("status bit not cleared by a write of one");

  count_hold_a: assert property ( // R12
    @(posedge i_sys_clk) disable iff (i_rst)
    !tick |=> $stable(st_reg.count)
  ) else $error("count moved without a tick");

  bit7_mode_map_a: assert property ( // R9
    @(posedge i_sys_clk) disable iff (i_rst)
    !st_reg.ctrl[`RTP_BIT_ERRSEL] |=> (!o_sp_bit7_to_fe &&
      (o_sp_bit7_read == $past(i_sp_mode_bit)))
  ) else $error("bit 7 not mapped to mode bit");

  baud_double_off_a: assert property ( // R8
    @(posedge i_sys_clk) disable iff (i_rst)
    !(st_reg.ctrl[`RTP_BIT_DOUBLE] && i_sp_mode2) |=> !o_sp_baud_double
  ) else $error("second port baud doubled outside mode 2");

  pready_pulse_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_pready |=> !o_pready
  ) else $error("ready held longer than one cycle");

  slverr_with_ready_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_pslverr |-> o_pready
  ) else $error("error response without ready");

  prdata_idle_zero_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !o_pready |-> (o_prdata == 32'h0000_0000)
  ) else $error("read data not zero outside access");

  reload_low_hold_a: assert property ( // R10
    @(posedge i_sys_clk) disable iff (i_rst)
    !wr_rlow |=> $stable(st_reg.rlow)
  ) else $error("reload low byte changed without a write");

  reload_high_hold_a: assert property ( // R11
    @(posedge i_sys_clk) disable iff (i_rst)
    !wr_rhigh |=> $stable(st_reg.rhigh)
  ) else $error("reload high byte changed without a write");

endmodule
`default_nettype wire

//--- dv/rtp_timer_tb_top.sv
// Purpose: Self-checking bench for the reload timer through its APB registers
// Assumes: One clock; the bench drives every port itself, no partner model
// Notes:   Observation counters run on the falling edge so reads in the main flow never race
`timescale 1ns/1ps
`default_nettype none
`include "rtp_defs.svh"
module rtp_timer_tb_top;
  localparam logic [11:0] A_CTRL  = {2'b00, `RTP_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_RLOW  = {2'b00, `RTP_IDX_RLOW, 2'b00};
  localparam logic [11:0] A_RHIGH = {2'b00, `RTP_IDX_RHIGH, 2'b00};
  localparam logic [11:0] A_COUNT = {2'b00, `RTP_IDX_COUNT, 2'b00};
  localparam logic [11:0] A_ISTAT = {2'b00, `RTP_IDX_ISTAT, 2'b00};
  localparam logic [11:0] A_IMASK = {2'b00, `RTP_IDX_IMASK, 2'b00};
  localparam logic [11:0] A_BAD   = 12'h400;
  localparam int unsigned CYC_LIMIT = 95000;

  logic        i_sys_clk;
  logic        i_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        o_pready;
  logic [31:0] o_prdata;
  logic        o_pslverr;
  logic        i_isr_enter;
  logic        o_irq;
  logic        i_timer1_ovf;
  logic        i_sp_mode2;
  logic        i_sp_mode_bit;
  logic        i_sp_framing_error;
  logic        o_uart0_baud_tick;
  logic        o_sp_baud_double;
  logic        o_sp_bit7_read;
  logic        o_sp_bit7_to_fe;
  logic [31:0] rd;
  logic        err;
  int unsigned mismatches;
  int unsigned tests_run;
  int unsigned cyc;
  int unsigned baud_cnt;

  rtp_timer dut_u (
    .i_sys_clk          (i_sys_clk),
    .i_rst              (i_rst),
    .i_psel             (psel),
    .i_penable          (penable),
    .i_pwrite           (pwrite),
    .i_paddr            (paddr),
    .i_pwdata           (pwdata),
    .o_pready           (o_pready),
    .o_prdata           (o_prdata),
    .o_pslverr          (o_pslverr),
    .i_isr_enter        (i_isr_enter),
    .o_irq              (o_irq),
    .i_timer1_ovf       (i_timer1_ovf),
    .i_sp_mode2         (i_sp_mode2),
    .i_sp_mode_bit      (i_sp_mode_bit),
    .i_sp_framing_error (i_sp_framing_error),
    .o_uart0_baud_tick  (o_uart0_baud_tick),
    .o_sp_baud_double   (o_sp_baud_double),
    .o_sp_bit7_read     (o_sp_bit7_read),
    .o_sp_bit7_to_fe    (o_sp_bit7_to_fe)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Called just after a rising edge; ends one idle edge later so psel never toggles twice at once
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_pready !== 1'b1);
    // No wait states: ready answers in the first access cycle
    check("pready wait", 32'(n), 32'h1);
    rd      = o_prdata;
    err     = o_pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(name, rd, exp);
    check({name, " err"}, {31'h0, err}, 32'h0);
  endtask

  task automatic t1_pulses(input int n);
    repeat (n) begin
      i_timer1_ovf <= 1'b1;
      @(posedge i_sys_clk);
      i_timer1_ovf <= 1'b0;
      @(posedge i_sys_clk);
    end
    repeat (2) @(posedge i_sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (o_uart0_baud_tick === 1'b1) baud_cnt <= baud_cnt + 1;
    if (cyc == CYC_LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    int unsigned t1;
    int unsigned b1;
    int n;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {i_isr_enter, i_timer1_ovf, i_sp_mode2, i_sp_mode_bit, i_sp_framing_error} = '0;
    mismatches = 0;
    tests_run = 0;
    cyc = 0;
    baud_cnt = 0;
    i_rst = 1'b1;
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    check("irq rst", {31'h0, o_irq}, 32'h0);
    rd_chk("ctrl rst", A_CTRL, 32'h0);
    rd_chk("rlow rst", A_RLOW, 32'h0);
    rd_chk("rhigh rst", A_RHIGH, 32'h0);
    rd_chk("istat rst", A_ISTAT, 32'h0);
    rd_chk("imask rst", A_IMASK, 32'h0);
    apb(1'b1, A_RLOW, 32'hFFFF_FFA5);
    apb(1'b1, A_RHIGH, 32'h1234_565A);
    rd_chk("rlow rw", A_RLOW, 32'h0000_00A5);
    rd_chk("rhigh rw", A_RHIGH, 32'h0000_005A);
    apb(1'b1, A_BAD, 32'h0000_00FF);
    check("bad wr err", {31'h0, err}, 32'h1);
    apb(1'b0, A_BAD, 32'h0);
    check("bad rd err", {31'h0, err}, 32'h1);
    check("bad rd data", rd, 32'h0);
    apb(1'b1, A_COUNT, 32'h0000_FFFF);
    rd_chk("count ro", A_COUNT, 32'h0);
    rd_chk("ctrl after bad", A_CTRL, 32'h0);
    // Software sets and clears the flag; routine entry clears it too
    apb(1'b1, A_CTRL, 32'h0000_0010);
    rd_chk("flag sw set", A_CTRL, 32'h0000_0010);
    i_isr_enter <= 1'b1;
    @(posedge i_sys_clk);
    i_isr_enter <= 1'b0;
    @(posedge i_sys_clk);
    rd_chk("flag isr clr", A_CTRL, 32'h0);
    apb(1'b1, A_CTRL, 32'h0000_0010);
    apb(1'b1, A_CTRL, 32'h0000_0000);
    rd_chk("flag sw clr", A_CTRL, 32'h0);
    rd_chk("istat no evt", A_ISTAT, 32'h0);
    // Serial port hooks across all 16 combinations of bits 7 and 6, mode 2 and mode bit
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, A_CTRL, {24'h0, k[3], k[2], 6'h0});
      i_sp_mode2         <= k[1];
      i_sp_mode_bit      <= k[0];
      i_sp_framing_error <= ~k[0];
      repeat (2) @(posedge i_sys_clk);
      check("baud dbl", {31'h0, o_sp_baud_double}, {31'h0, k[3] & k[1]});
      check("bit7 rd", {31'h0, o_sp_bit7_read}, {31'h0, k[2] ? ~k[0] : k[0]});
      check("bit7 fe", {31'h0, o_sp_bit7_to_fe}, {31'h0, k[2]});
    end
    apb(1'b1, A_CTRL, 32'h0);
    b1 = baud_cnt;
    t1_pulses(3);
    check("baud t1", baud_cnt - b1, 32'd3);
    apb(1'b1, A_CTRL, 32'h0000_0020);
    b1 = baud_cnt;
    t1_pulses(3);
    check("baud t1 off", baud_cnt - b1, 32'd0);
    // Each code runs three and a half periods (code 0 only three) from a prescaler restarted at zero, so exactly three ticks land
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, A_CTRL, 32'h0000_0008 | c);
      repeat (3 * (1 << c) + ((1 << c) >> 1) - 3) @(posedge i_sys_clk);
      apb(1'b1, A_CTRL, 32'h0);
      rd_chk("count pre", A_COUNT, 32'd3 * (c + 1));
    end
    repeat (40) @(posedge i_sys_clk);
    rd_chk("count halt", A_COUNT, 32'd24);
    // Long first climb to the top, then short reload periods
    // written while halted
    apb(1'b1, A_RLOW, 32'h0000_00F8);
    apb(1'b1, A_RHIGH, 32'h0000_00FF);
    apb(1'b1, A_IMASK, 32'h1);
    apb(1'b1, A_CTRL, 32'h0000_0028);
    n = 0;
    while (o_irq !== 1'b1 && n < 70000) begin
      @(posedge i_sys_clk);
      n++;
    end
    t1 = cyc;
    b1 = baud_cnt;
    apb(1'b1, A_ISTAT, 32'h1);
    n = 0;
    while (o_irq !== 1'b1 && n < 40) begin
      @(posedge i_sys_clk);
      n++;
    end
    check("reload period", cyc - t1, 32'd8);
    check("baud ovf", baud_cnt - b1, 32'd1);
    rd_chk("flag hw", A_CTRL, 32'h0000_0038);
    rd_chk("istat evt", A_ISTAT, 32'h1);
    apb(1'b1, A_CTRL, 32'h0);
    rd_chk("istat kept", A_ISTAT, 32'h1);
    apb(1'b1, A_IMASK, 32'h0);
    check("irq masked", {31'h0, o_irq}, 32'h0);
    apb(1'b1, A_IMASK, 32'h1);
    check("irq unmasked", {31'h0, o_irq}, 32'h1);
    apb(1'b1, A_ISTAT, 32'h1);
    check("irq w1c", {31'h0, o_irq}, 32'h0);
    rd_chk("istat w1c", A_ISTAT, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
